// file: rtl/vcp_pkg.sv
/*
  Shared constants, types and helpers for the virtual console port device:
  register offsets, feature bit positions, queue numbering, control event
  codes and the byte-order helpers used by the register file and control path.
  Assumes a 32-bit AHB-Lite register bus and word-aligned single transfers.
*/
package vcp_pkg;
  localparam logic [7:0]  OFS_FEAT_OFFER = 8'h00;
  localparam logic [7:0]  OFS_FEAT_ACK   = 8'h04;
  localparam logic [7:0]  OFS_CTRL       = 8'h08;
  localparam logic [7:0]  OFS_COLS       = 8'h0C;
  localparam logic [7:0]  OFS_ROWS       = 8'h10;
  localparam logic [7:0]  OFS_PORT_LIMIT = 8'h14;
  localparam logic [7:0]  OFS_EMERG      = 8'h18;
  localparam logic [7:0]  OFS_STATUS     = 8'h1C;
  localparam logic [7:0]  OFS_PORT_EXIST = 8'h20;
  localparam logic [7:0]  OFS_PORT_UP    = 8'h24;
  localparam logic [23:0] ADDR_HI_ZERO   = 24'h000000;
  localparam logic [31:0] REG_ZERO       = 32'h00000000;
  localparam int          FB_SIZE        = 0;
  localparam int          FB_MULTI       = 1;
  localparam int          FB_EMERG       = 2;
  localparam int          CTL_LEGACY     = 0;
  localparam int          STS_DRV_READY  = 0;
  localparam int          HTRANS_ACT_BIT = 1;
  localparam logic        HRESP_OKAY     = 1'b0;
  localparam logic [15:0] Q_P0_RX        = 16'h0000;
  localparam logic [15:0] Q_P0_TX        = 16'h0001;
  localparam logic [15:0] Q_CTL_RX       = 16'h0002;
  localparam logic [15:0] Q_CTL_TX       = 16'h0003;
  localparam logic [15:0] Q_PAIR_BASE    = 16'h0004;
  localparam logic [15:0] EV_DRV_READY   = 16'h0000;
  localparam logic [15:0] EV_PORT_ADD    = 16'h0001;
  localparam logic [15:0] EV_PORT_REMOVE = 16'h0002;
  localparam logic [15:0] EV_PORT_READY  = 16'h0003;
  localparam logic [15:0] VAL_OK         = 16'h0001;
  localparam logic [15:0] VAL_UNUSED     = 16'h0000;

  typedef struct packed {
    logic [31:0] id;
    logic [15:0] event_code;
    logic [15:0] value;
  } vcp_msg_t;

  function automatic logic [15:0] vcp_sw16(input logic [15:0] v, input logic en);
    return en ? {v[7:0], v[15:8]} : v;
  endfunction

  function automatic logic [31:0] vcp_sw32(input logic [31:0] v, input logic en);
    return en ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
  endfunction

  // Self-inverse: converts between field values and the byte image on the queue
  function automatic vcp_msg_t vcp_msg_fmt(input vcp_msg_t m, input logic en);
    vcp_msg_t r;
    r.id         = vcp_sw32(m.id, en);
    r.event_code = vcp_sw16(m.event_code, en);
    r.value      = vcp_sw16(m.value, en);
    return r;
  endfunction

  function automatic logic [31:0] vcp_q_port(input logic [15:0] q);
    logic [15:0] d;
    d = q - Q_PAIR_BASE;
    return (q < Q_PAIR_BASE) ? REG_ZERO : 32'(d[15:1]) + 32'h00000001;
  endfunction

  function automatic logic vcp_q_exists(input logic [15:0] q, input logic multi,
                                        input logic [31:0] limit);
    if (q <= Q_P0_TX) return 1'b1;
    if (!multi) return 1'b0;
    if (q <= Q_CTL_TX) return 1'b1;
    return vcp_q_port(q) < limit;
  endfunction

  function automatic logic [15:0] vcp_rx_q(input logic [15:0] port);
    logic [15:0] d;
    d = port - 16'h0001;
    return (port == 16'h0000) ? Q_P0_RX : Q_PAIR_BASE + {d[14:0], 1'b0};
  endfunction
endpackage

// file: rtl/vcp_ctrl_if.sv
/*
  Carrier between the register core and the control-queue sequencer.
  Assumes both ends share one clock; message words are queue byte images.
*/
`timescale 1ns/10ps
interface vcp_ctrl_if #(parameter int N = 4);
  logic                 multi_en;
  logic                 swap_en;
  logic [31:0]          limit;
  logic                 add_valid;
  logic                 add_ready;
  logic                 add_remove;
  logic [31:0]          add_id;
  logic                 reject;
  logic                 drv_valid;
  logic                 drv_ready_hs;
  vcp_pkg::vcp_msg_t    drv_msg;
  logic                 dev_valid;
  logic                 dev_ready_hs;
  vcp_pkg::vcp_msg_t    dev_msg;
  logic [N-1:0]         port_exist;
  logic [N-1:0]         port_up;
  logic                 drv_ready;

  modport core (output multi_en, swap_en, limit, add_valid, add_remove, add_id,
                output drv_valid, drv_msg, dev_ready_hs,
                input  add_ready, reject, drv_ready_hs, dev_valid, dev_msg,
                input  port_exist, port_up, drv_ready);
  modport ctrl (input  multi_en, swap_en, limit, add_valid, add_remove, add_id,
                input  drv_valid, drv_msg, dev_ready_hs,
                output add_ready, reject, drv_ready_hs, dev_valid, dev_msg,
                output port_exist, port_up, drv_ready);
endinterface

// file: rtl/vcp_ctrl.sv
/*
  Control-queue sequencer: waits for the driver's ready message, then turns
  port add and remove requests into device-to-driver control messages.
  Assumes the driver side drains one message at a time with a handshake.
*/
`timescale 1ns/10ps
module vcp_ctrl #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  vcp_ctrl_if.ctrl cif
);
  import vcp_pkg::*;
  localparam int IW = (N > 1) ? $clog2(N) : 1;

  typedef enum logic [1:0] {
    S_WAIT_DRV = 2'b00,
    S_ANNOUNCE = 2'b01,
    S_SEND     = 2'b10
  } vcp_cst_t;

  typedef struct packed {
    vcp_cst_t     st;
    logic [N-1:0] exist;
    logic [N-1:0] up;
    vcp_msg_t     msg;
    logic         reject;
  } vcp_cstate_t;

  vcp_cstate_t st_r;
  vcp_cstate_t st_nxt;
  vcp_msg_t    rx_m;
  vcp_msg_t    tx_m;
  logic        add_in_range;
  logic        drv_in_range;

  assign rx_m            = vcp_msg_fmt(cif.drv_msg, cif.swap_en);
  assign add_in_range    = (cif.add_id < cif.limit) && (cif.add_id < 32'(N));
  assign drv_in_range    = rx_m.id < 32'(N);
  assign cif.drv_ready_hs = 1'b1;
  assign cif.add_ready   = (st_r.st == S_ANNOUNCE);
  assign cif.dev_valid   = (st_r.st == S_SEND);
  assign cif.dev_msg     = st_r.msg;
  assign cif.reject      = st_r.reject;
  assign cif.port_exist  = st_r.exist;
  assign cif.port_up     = st_r.up;
  assign cif.drv_ready   = (st_r.st != S_WAIT_DRV);

  always_comb begin
    st_nxt        = st_r;
    st_nxt.reject = 1'b0;
    tx_m.id         = cif.add_id;
    tx_m.event_code = cif.add_remove ? EV_PORT_REMOVE : EV_PORT_ADD;
    tx_m.value      = VAL_UNUSED;
    // Port-ready only counts for a port already announced
    if (cif.drv_valid && rx_m.event_code == EV_PORT_READY && drv_in_range &&
        st_r.exist[rx_m.id[IW-1:0]]) begin
      st_nxt.up[rx_m.id[IW-1:0]] = (rx_m.value == VAL_OK);
    end
    case (st_r.st)
      S_WAIT_DRV: begin
        if (cif.drv_valid && rx_m.event_code == EV_DRV_READY &&
            rx_m.value == VAL_OK) begin
          st_nxt.st = S_ANNOUNCE;
        end
      end
      S_ANNOUNCE: begin
        if (cif.add_valid) begin
          if (add_in_range && (st_r.exist[cif.add_id[IW-1:0]] == cif.add_remove)) begin
            st_nxt.exist[cif.add_id[IW-1:0]] = !cif.add_remove;
            if (cif.add_remove) begin
              st_nxt.up[cif.add_id[IW-1:0]] = 1'b0;
            end
            st_nxt.msg = vcp_msg_fmt(tx_m, cif.swap_en);
            st_nxt.st  = S_SEND;
          end else begin
            st_nxt.reject = 1'b1;
          end
        end
      end
      S_SEND: begin
        if (cif.dev_ready_hs) begin
          st_nxt.st = S_ANNOUNCE;
        end
      end
      default: st_nxt.st = S_WAIT_DRV;
    endcase
    // Dropping multiport tears down every port and the handshake
    if (!cif.multi_en) begin
      st_nxt.st    = S_WAIT_DRV;
      st_nxt.exist = '0;
      st_nxt.up    = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  chk_send_from_accept: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.st == S_ANNOUNCE && cif.add_valid && !st_nxt.reject) |=> cif.dev_valid)
    else $error("accepted port request produced no control message");
endmodule

// file: rtl/vcp_console_dev.sv
/*
  Virtual console port device core: AHB-Lite register file holding the
  feature, console size, port limit and emergency output fields, port zero
  and multiport queue decode, receive-buffer completion and the control path.
  Assumes zero-wait single word transfers and a queue engine outside.
*/
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
module vcp_console_dev #(
  parameter int   MAX_PORTS   = 4,
  parameter bit   GUEST_BIG   = 1'b0,
  parameter bit   OFFER_SIZE  = 1'b1,
  parameter bit   OFFER_MULTI = 1'b1,
  parameter bit   OFFER_EMERG = 1'b1
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output      logic                   hreadyout,
  output      logic [31:0]            hrdata,
  output      logic                   hresp,
  input  wire logic [15:0]            con_cols,
  input  wire logic [15:0]            con_rows,
  input  wire logic                   con_size_upd,
  output      logic                   cfg_change_ntf,
  output      logic                   emerg_valid,
  output      logic [7:0]             emerg_char,
  input  wire logic [15:0]            q_sel,
  output      logic                   q_exists,
  output      logic [31:0]            q_port,
  input  wire logic                   rx_valid,
  output      logic                   rx_ready,
  input  wire logic [15:0]            rx_port,
  input  wire logic [7:0]             rx_byte,
  input  wire logic [MAX_PORTS-1:0]   rx_buf_avail,
  output      logic                   used_ntf,
  output      logic [15:0]            used_queue,
  output      logic [7:0]             used_byte,
  input  wire logic                   hp_add_valid,
  output      logic                   hp_add_ready,
  input  wire logic                   hp_add_remove,
  input  wire logic [31:0]            hp_add_id,
  output      logic                   hp_add_reject,
  input  wire logic                   ctrl_tx_valid,
  output      logic                   ctrl_tx_ready,
  input  wire vcp_pkg::vcp_msg_t      ctrl_tx_msg,
  output      logic                   ctrl_rx_valid,
  input  wire logic                   ctrl_rx_ready,
  output      vcp_pkg::vcp_msg_t      ctrl_rx_msg
);
  import vcp_pkg::*;
  localparam int IW = (MAX_PORTS > 1) ? $clog2(MAX_PORTS) : 1;
  localparam logic [31:0] FEAT_OFFER = (32'(OFFER_SIZE) << FB_SIZE)
                                     | (32'(OFFER_MULTI) << FB_MULTI)
                                     | (32'(OFFER_EMERG) << FB_EMERG);
  localparam logic [31:0] LIMIT = 32'(MAX_PORTS);

  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_ofs;
    logic [31:0] rdata;
    logic [31:0] feat_ack;
    logic        legacy;
    logic [15:0] cols;
    logic [15:0] rows;
    logic        cfg_ntf;
    logic        emerg_v;
    logic [7:0]  emerg_c;
    logic        used_v;
    logic [15:0] used_q;
    logic [7:0]  used_b;
  } vcp_mstate_t;

  vcp_mstate_t st_r;
  vcp_mstate_t st_nxt;
  logic        acc;
  logic        addr_hit;
  logic [31:0] negotiated;
  logic        size_neg;
  logic        multi_neg;
  logic        swap;
  logic [31:0] wdata_le;
  logic [7:0]  emerg_byte;
  logic        rx_port_ok;
  vcp_msg_t    dev_plain;

  vcp_ctrl_if #(.N(MAX_PORTS)) cif ();

  vcp_ctrl #(.N(MAX_PORTS)) u_ctrl (
    .clk   (clk),
    .rst_n (rst_n),
    .cif   (cif.ctrl)
  );

  assign acc        = hsel && htrans[HTRANS_ACT_BIT] && hready;
  assign addr_hit   = (haddr[31:8] == ADDR_HI_ZERO);
  assign negotiated = st_r.feat_ack & FEAT_OFFER;
  assign size_neg   = negotiated[FB_SIZE];
  assign multi_neg  = negotiated[FB_MULTI];
  // Byte order only departs from little-endian for legacy, big-endian guests
  assign swap       = st_r.legacy && GUEST_BIG;
  assign wdata_le   = vcp_sw32(hwdata, swap);
  assign emerg_byte = wdata_le[7:0];

  assign cif.multi_en     = multi_neg;
  assign cif.swap_en      = swap;
  assign cif.limit        = LIMIT;
  assign cif.add_valid    = hp_add_valid;
  assign cif.add_remove   = hp_add_remove;
  assign cif.add_id       = hp_add_id;
  assign cif.drv_valid    = ctrl_tx_valid;
  assign cif.drv_msg      = ctrl_tx_msg;
  assign cif.dev_ready_hs = ctrl_rx_ready;
  assign hp_add_ready     = cif.add_ready;
  assign hp_add_reject    = cif.reject;
  assign ctrl_tx_ready    = cif.drv_ready_hs;
  assign ctrl_rx_valid    = cif.dev_valid;
  assign ctrl_rx_msg      = cif.dev_msg;
  assign dev_plain        = vcp_msg_fmt(cif.dev_msg, swap);

  assign q_exists = vcp_q_exists(q_sel, multi_neg, LIMIT);
  assign q_port   = vcp_q_port(q_sel);

  // Port zero takes input whenever its buffer is available; other ports only once announced
  assign rx_port_ok = (rx_port == 16'h0000) ||
                      (multi_neg && rx_port < 16'(MAX_PORTS) &&
                       cif.port_exist[rx_port[IW-1:0]]);
  assign rx_ready   = rx_port_ok && (rx_port < 16'(MAX_PORTS)) &&
                      rx_buf_avail[rx_port[IW-1:0]];

  assign hreadyout      = 1'b1;
  assign hresp          = HRESP_OKAY;
  assign hrdata         = st_r.rdata;
  assign cfg_change_ntf = st_r.cfg_ntf;
  assign emerg_valid    = st_r.emerg_v;
  assign emerg_char     = st_r.emerg_c;
  assign used_ntf       = st_r.used_v;
  assign used_queue     = st_r.used_q;
  assign used_byte      = st_r.used_b;

  always_comb begin
    st_nxt         = st_r;
    st_nxt.cfg_ntf = 1'b0;
    st_nxt.emerg_v = 1'b0;
    st_nxt.used_v  = 1'b0;
    st_nxt.wr_pend = acc && hwrite && addr_hit;
    st_nxt.wr_ofs  = haddr[7:0];
    // Data phase of a write: hwdata is valid now
    if (st_r.wr_pend) begin
      case (st_r.wr_ofs)
        OFS_FEAT_ACK: st_nxt.feat_ack = hwdata;
        OFS_CTRL:     st_nxt.legacy   = hwdata[CTL_LEGACY];
        OFS_EMERG: begin
          // No dependence on acknowledge or queue setup, so works before init
          if (FEAT_OFFER[FB_EMERG]) begin
            st_nxt.emerg_v = 1'b1;
            st_nxt.emerg_c = emerg_byte;
          end
        end
        default: st_nxt.feat_ack = st_r.feat_ack;
      endcase
    end
    // Read data is captured in the address phase to avoid a wait state
    // Writable fields come from st_nxt so a write still in its data phase is seen
    if (acc && !hwrite) begin
      st_nxt.rdata = REG_ZERO;
      if (addr_hit) begin
        case (haddr[7:0])
          OFS_FEAT_OFFER: st_nxt.rdata = FEAT_OFFER;
          OFS_FEAT_ACK:   st_nxt.rdata = st_nxt.feat_ack;
          OFS_CTRL:       st_nxt.rdata = 32'(st_nxt.legacy) << CTL_LEGACY;
          OFS_COLS:       st_nxt.rdata = 32'(vcp_sw16(st_r.cols, swap));
          OFS_ROWS:       st_nxt.rdata = 32'(vcp_sw16(st_r.rows, swap));
          OFS_PORT_LIMIT: st_nxt.rdata = FEAT_OFFER[FB_MULTI] ?
                                         vcp_sw32(LIMIT, swap) : REG_ZERO;
          OFS_EMERG:      st_nxt.rdata = REG_ZERO;
          OFS_STATUS:     st_nxt.rdata = 32'(cif.drv_ready) << STS_DRV_READY;
          OFS_PORT_EXIST: st_nxt.rdata = 32'(cif.port_exist);
          OFS_PORT_UP:    st_nxt.rdata = 32'(cif.port_up);
          default:        st_nxt.rdata = REG_ZERO;
        endcase
      end
    end
    // Size is tracked always; the change is only signalled when negotiated
    if (con_size_upd) begin
      st_nxt.cols    = con_cols;
      st_nxt.rows    = con_rows;
      st_nxt.cfg_ntf = size_neg;
    end
    if (rx_valid && rx_ready) begin
      st_nxt.used_v = 1'b1;
      st_nxt.used_q = vcp_rx_q(rx_port);
      st_nxt.used_b = rx_byte;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_emerg_low_byte: assert property (
    (st_r.wr_pend && st_r.wr_ofs == OFS_EMERG && FEAT_OFFER[FB_EMERG])
      |=> (emerg_valid && emerg_char == $past(emerg_byte)))
    else $error("emergency write did not forward its low byte");

  chk_emerg_any_time: assert property (
    (acc && hwrite && haddr == {ADDR_HI_ZERO, OFS_EMERG} && FEAT_OFFER[FB_EMERG])
      |-> ##2 emerg_valid)
    else $error("emergency write was not accepted");

  chk_emerg_read_zero: assert property (
    (acc && !hwrite && haddr == {ADDR_HI_ZERO, OFS_EMERG}) |=> hrdata == REG_ZERO)
    else $error("emergency field read was not zero");

  chk_limit_read: assert property (
    (acc && !hwrite && haddr == {ADDR_HI_ZERO, OFS_PORT_LIMIT} && !swap &&
     FEAT_OFFER[FB_MULTI]) |=> hrdata == LIMIT)
    else $error("port limit read returned a wrong value");

  chk_size_notify: assert property (
    (con_size_upd && size_neg)
      |=> (cfg_change_ntf && st_r.cols == $past(con_cols) && st_r.rows == $past(con_rows)))
    else $error("size change not notified or not latched");

  chk_size_quiet: assert property (
    !size_neg |=> !cfg_change_ntf)
    else $error("size notification without negotiated size feature");

  chk_port0_queues: assert property (
    (q_sel <= Q_P0_TX) |-> (q_exists && q_port == REG_ZERO))
    else $error("port zero queue reported missing");

  chk_ctl_queues: assert property (
    (q_sel == Q_CTL_RX || q_sel == Q_CTL_TX) |-> (q_exists == multi_neg))
    else $error("control queue presence does not follow multiport");

  chk_rx_used: assert property (
    (rx_valid && rx_ready)
      |=> (used_ntf && used_queue == vcp_rx_q($past(rx_port)) &&
           used_byte == $past(rx_byte)))
    else $error("receive buffer not marked used on its queue");

  chk_ready_before_add: assert property (
    ctrl_rx_valid |-> cif.drv_ready)
    else $error("port message sent before driver ready");

  chk_no_dup_add: assert property (
    (hp_add_valid && hp_add_ready && !hp_add_remove &&
     (hp_add_id >= LIMIT || cif.port_exist[hp_add_id[IW-1:0]]))
      |=> (hp_add_reject && !ctrl_rx_valid))
    else $error("duplicate or out-of-range port was added");

  chk_msg_held: assert property (
    (ctrl_rx_valid && !ctrl_rx_ready) |=> (ctrl_rx_valid && $stable(ctrl_rx_msg)))
    else $error("control message dropped before it was taken");

  chk_msg_fields: assert property (
    ctrl_rx_valid |-> (dev_plain.id < LIMIT && dev_plain.value == VAL_UNUSED &&
      (dev_plain.event_code == EV_PORT_ADD || dev_plain.event_code == EV_PORT_REMOVE)))
    else $error("control message fields malformed");

  chk_offer_read: assert property (
    (acc && !hwrite && haddr == {ADDR_HI_ZERO, OFS_FEAT_OFFER})
      |=> (hrdata[FB_SIZE] == OFFER_SIZE && hrdata[FB_MULTI] == OFFER_MULTI &&
           hrdata[FB_EMERG] == OFFER_EMERG))
    else $error("feature offer read does not match the offered set");

  chk_rx_port_gate: assert property (
    (rx_ready && rx_port != 16'h0000) |-> (multi_neg && rx_port < 16'(MAX_PORTS)))
    else $error("input accepted on a port that cannot exist");

  chk_q_limit: assert property (
    (q_sel >= Q_PAIR_BASE && q_port >= LIMIT) |-> !q_exists)
    else $error("queue reported beyond the port-count limit");

  chk_ports_need_multi: assert property (
    !multi_neg |=> (cif.port_exist == '0 && !ctrl_rx_valid))
    else $error("ports kept without negotiated multiport");

  chk_status_read: assert property (
    (acc && !hwrite && haddr == {ADDR_HI_ZERO, OFS_STATUS})
      |=> hrdata[STS_DRV_READY] == $past(cif.drv_ready))
    else $error("driver-ready status read back wrong");

  chk_add_marks_exist: assert property (
    (ctrl_rx_valid && dev_plain.event_code == EV_PORT_ADD) |-> cif.port_exist[dev_plain.id[IW-1:0]])
    else $error("announced port not recorded as existing");

  cov_emerg_write:  cover property (emerg_valid);
  cov_port_add:     cover property (ctrl_rx_valid && ctrl_rx_ready &&
                                    dev_plain.event_code == EV_PORT_ADD);
  cov_rx_used_pN:   cover property (used_ntf && used_queue >= Q_PAIR_BASE);
  cov_size_change:  cover property (cfg_change_ntf);
  cov_port_remove:  cover property (ctrl_rx_valid && ctrl_rx_ready &&
                                    dev_plain.event_code == EV_PORT_REMOVE);
endmodule

// file: test/vcp_drv_model.sv
/*
  Guest driver model on the control queues: sends driver-to-device messages
  and drains device-to-driver messages after a programmable stall.
  Assumes the device's control handshakes of the console device core.
*/
`timescale 1ns/10ps
module vcp_drv_model
  import vcp_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_n,
  output      logic     tx_valid,
  input  wire logic     tx_ready,
  output      vcp_msg_t tx_msg,
  input  wire logic     rx_valid,
  output      logic     rx_ready,
  input  wire vcp_msg_t rx_msg
);
  int       stall = 2;
  int       wait_n;
  int       got;
  vcp_msg_t last;

  initial begin
    tx_valid = 1'b0;
    tx_msg   = '0;
  end

  // Released message shows its inverse so stale data never looks valid
  task automatic send(input vcp_msg_t m);
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_msg   <= m;
    do @(posedge clk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    tx_msg   <= ~m;
  endtask

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ready <= 1'b0;
      wait_n   <= 0;
    end else if (rx_valid && !rx_ready) begin
      if (wait_n >= stall) begin
        rx_ready <= 1'b1;
        last     <= rx_msg;
        got      <= got + 1;
      end else begin
        wait_n <= wait_n + 1;
      end
    end else begin
      rx_ready <= 1'b0;
      wait_n   <= 0;
    end
  end
endmodule

// file: test/vcp_console_dev_tb.sv
/*
  Self-checking bench for the console device core: register reads and
  writes over AHB-Lite, queue decode, size change, receive and port control.
  Assumes the zero-wait register bus and the driver model beside it.
*/
`timescale 1ns/10ps
module vcp_console_dev_tb;
  import vcp_pkg::*;
  logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, csu, cfg, ev, un;
  logic hav, har, harem, rej, tv, tr, rv, rr, rxv, rxr;
  logic [31:0] haddr, hwdata, hrdata, hid, qp, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] cols, rows, qs, rxp, uq_o, uq;
  logic [7:0]  ec, rxb, ub_o, ub, em_c;
  logic [3:0]  bav;
  logic        qe;
  vcp_msg_t    tm, rm;
  int fail_count, checks_done, n_em, n_cfg, n_rej, cyc;

  assign hready = hreadyout;
  vcp_console_dev DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .con_cols(cols), .con_rows(rows), .con_size_upd(csu),
    .cfg_change_ntf(cfg), .emerg_valid(ev), .emerg_char(ec), .q_sel(qs), .q_exists(qe),
    .q_port(qp), .rx_valid(rxv), .rx_ready(rxr), .rx_port(rxp), .rx_byte(rxb),
    .rx_buf_avail(bav), .used_ntf(un), .used_queue(uq_o), .used_byte(ub_o),
    .hp_add_valid(hav), .hp_add_ready(har), .hp_add_remove(harem), .hp_add_id(hid),
    .hp_add_reject(rej), .ctrl_tx_valid(tv), .ctrl_tx_ready(tr), .ctrl_tx_msg(tm),
    .ctrl_rx_valid(rv), .ctrl_rx_ready(rr), .ctrl_rx_msg(rm));
  vcp_drv_model drv (.clk(clk), .rst_n(rst_n), .tx_valid(tv), .tx_ready(tr), .tx_msg(tm),
    .rx_valid(rv), .rx_ready(rr), .rx_msg(rm));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (ev) begin n_em <= n_em + 1; em_c <= ec; end
    if (cfg) n_cfg <= n_cfg + 1;
    if (rej) n_rej <= n_rej + 1;
    if (un) begin uq <= uq_o; ub <= ub_o; end
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d; haddr <= ~a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic add(input logic r, input logic [31:0] id);
    @(posedge clk);
    hav <= 1'b1; harem <= r; hid <= id;
    do @(posedge clk); while (har !== 1'b1);
    hav <= 1'b0; hid <= ~id;
    repeat (8) @(posedge clk);
  endtask

  task automatic qchk(input logic [15:0] q, input logic e);
    @(posedge clk); qs <= q;
    @(posedge clk); chk(32'(qe), 32'(e));
  endtask

  task automatic rx(input logic [15:0] p, input logic [7:0] b);
    @(posedge clk); rxv <= 1'b1; rxp <= p; rxb <= b;
    do @(posedge clk); while (rxr !== 1'b1);
    rxv <= 1'b0; rxb <= ~b;
    repeat (3) @(posedge clk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
    haddr = 32'h0; hwdata = 32'h0; cols = 16'h0; rows = 16'h0; csu = 1'b0; qs = 16'h0;
    rxv = 1'b0; rxp = 16'h0; rxb = 8'h0; bav = 4'hF; hav = 1'b0; harem = 1'b0; hid = 32'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    ahb(1'b0, 32'h00, 32'h0); chk(rd, 32'h7); chk(32'(hresp), 32'h0);
    ahb(1'b0, 32'h100, 32'h0); chk(rd, 32'h0);
    ahb(1'b1, 32'h08, 32'h1); ahb(1'b0, 32'h08, 32'h0); chk(rd, 32'h1);
    ahb(1'b0, 32'h14, 32'h0); chk(rd, 32'h4);
    ahb(1'b0, 32'h18, 32'h0); chk(rd, 32'h0);
    ahb(1'b1, 32'h18, 32'hA5A5A55A); repeat (2) @(posedge clk);
    chk(n_em, 1); chk(32'(em_c), 32'h5A);
    $display("test registers and early output done");
    qchk(16'h1, 1'b1); qchk(16'h2, 1'b0);
    ahb(1'b1, 32'h04, 32'h3); ahb(1'b0, 32'h04, 32'h0); chk(rd, 32'h3);
    qchk(16'h3, 1'b1); qchk(16'h5, 1'b1); chk(qp, 32'h1); qchk(16'hA, 1'b0);
    $display("test queue decode done");
    @(posedge clk); cols <= 16'h50; rows <= 16'h18; csu <= 1'b1;
    @(posedge clk); csu <= 1'b0; repeat (3) @(posedge clk);
    chk(n_cfg, 1); ahb(1'b0, 32'h0C, 32'h0); chk(rd, 32'h50);
    ahb(1'b0, 32'h10, 32'h0); chk(rd, 32'h18);
    $display("test size change done");
    ahb(1'b0, 32'h1C, 32'h0); chk(rd, 32'h0);
    drv.send('{32'h0, EV_DRV_READY, VAL_OK});
    ahb(1'b0, 32'h1C, 32'h0); chk(rd, 32'h1);
    add(1'b0, 32'h1); chk(drv.got, 1); chk(drv.last.id, 32'h1);
    chk(32'({drv.last.event_code, drv.last.value}), 32'h00010000);
    ahb(1'b0, 32'h20, 32'h0); chk(rd, 32'h2);
    add(1'b0, 32'h1); chk(n_rej, 1); add(1'b0, 32'h4); chk(n_rej, 2);
    drv.stall = 0;
    drv.send('{32'h1, EV_PORT_READY, VAL_OK});
    ahb(1'b0, 32'h24, 32'h0); chk(rd, 32'h2);
    $display("test port control done");
    @(posedge clk); bav <= 4'hD; rxp <= 16'h1; @(posedge clk); chk(32'(rxr), 32'h0);
    bav <= 4'hF;
    rx(16'h1, 8'h33); chk(32'(uq), 32'h4); chk(32'(ub), 32'h33);
    rx(16'h0, 8'hC4); chk(32'(uq), 32'h0); chk(32'(ub), 32'hC4);
    $display("test receive done");
    add(1'b1, 32'h1); chk(drv.got, 2); chk(32'(drv.last.event_code), 32'h2);
    ahb(1'b0, 32'h20, 32'h0); chk(rd, 32'h0); add(1'b1, 32'h1); chk(n_rej, 3);
    $display("test port removal done");
    close_out();
  end
endmodule
